// File: verilog/trs_pkg.sv
package trs_pkg;

    // ----------------------------------------------------------------
    // Inputs and priorities
    // ----------------------------------------------------------------
    localparam int NUM_LINE = 3;
    localparam int NUM_IN   = NUM_LINE + 1;
    localparam int PRIO_W   = 3;
    localparam int IDX_W    = 2;
    localparam int ADDR_W   = 12;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int TICK_PERIOD_MS = 100;
    localparam int TICK_CYCLES    =
        (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
    localparam int MINUTE_MS      = 60000;
    localparam int TICKS_PER_MIN  = MINUTE_MS / TICK_PERIOD_MS;
    localparam int WTR_MAX_MIN    = 12;
    localparam int TMR_W          = 13;
    localparam int LINK_PERIOD_NS = 800;
    localparam int LINK_CYCLES    = LINK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int ACT_LIMIT      = 4 * LINK_CYCLES;
    localparam int ACT_W          = 6;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_PRIO   = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_WTR    = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_HOT    = 12'h00c;
    localparam logic [ADDR_W-1:0] ADDR_CMD    = 12'h010;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h014;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SQ_BIT   = 2;
    localparam int CTRL_MON_BIT  = 3;
    localparam int CMD_IDX_LSB   = 4;

    localparam int ST_SEL_LSB    = 0;
    localparam int ST_VALID_BIT  = 2;
    localparam int ST_HOLD_BIT   = 3;
    localparam int ST_LOSS_BIT   = 4;
    localparam int ST_FS_BIT     = 5;
    localparam int ST_MS_BIT     = 6;
    localparam int ST_MODE_LSB   = 8;
    localparam int ST_LOCK_LSB   = 12;
    localparam int ST_UNUS_LSB   = 16;
    localparam int ST_WTR_LSB    = 20;

    localparam logic [1:0] CTRL_MODE_RST = 2'h0;
    localparam logic       CTRL_SQ_RST   = 1'h0;
    localparam logic       CTRL_MON_RST  = 1'h1;
    localparam logic [3:0] WTR_RST       = 4'h5;
    localparam logic [3:0] HOT_RST       = 4'h3;

    // ----------------------------------------------------------------
    // Codes
    // ----------------------------------------------------------------
    localparam logic [2:0] CMD_CLEAR       = 3'h1;
    localparam logic [2:0] CMD_LOCKOUT     = 3'h2;
    localparam logic [2:0] CMD_CLR_LOCKOUT = 3'h3;
    localparam logic [2:0] CMD_FORCED      = 3'h4;
    localparam logic [2:0] CMD_MANUAL      = 3'h5;

    localparam logic [1:0] MODE_FREE   = 2'h0;
    localparam logic [1:0] MODE_LOCKED = 2'h1;
    localparam logic [1:0] MODE_HOLD   = 2'h2;

endpackage

// File: verilog/trs_fail_timer.sv
`timescale 1ns/100ps
`default_nettype none

module trs_fail_timer #(
    parameter int CNT_W = trs_pkg::TMR_W
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             tick,
    input  wire logic             raw_fail,
    input  wire logic [3:0]       hold_ticks,
    input  wire logic [CNT_W-1:0] wtr_ticks,
    output logic                  unusable,
    output logic                  restoring
);

    typedef enum logic [1:0] {
        TS_OK,
        TS_HOLD,
        TS_FAIL,
        TS_WTR
    } trs_tmr_st_t;

    typedef struct packed {
        trs_tmr_st_t      st;
        logic [CNT_W-1:0] cnt;
    } trs_tmr_t;

    trs_tmr_t q;
    trs_tmr_t next_q;

    // ----------------------------------------------------------------
    // Hold-off and restore sequencing
    // ----------------------------------------------------------------
    always_comb begin
        next_q = q;
        case (q.st)
            TS_OK: begin
                if (raw_fail) begin
                    if (hold_ticks == 4'h0) begin
                        next_q.st = TS_FAIL;
                    end else begin
                        next_q.st  = TS_HOLD;
                        next_q.cnt = CNT_W'(hold_ticks);
                    end
                end
            end
            TS_HOLD: begin
                // Short glitches never reach selection
                if (!raw_fail) begin
                    next_q.st = TS_OK;
                end else if (tick) begin
                    if (q.cnt <= CNT_W'(1)) begin
                        next_q.st = TS_FAIL;
                    end else begin
                        next_q.cnt = q.cnt - CNT_W'(1);
                    end
                end
            end
            TS_FAIL: begin
                if (!raw_fail) begin
                    if (wtr_ticks == '0) begin
                        next_q.st = TS_OK;
                    end else begin
                        next_q.st  = TS_WTR;
                        next_q.cnt = wtr_ticks;
                    end
                end
            end
            TS_WTR: begin
                if (raw_fail) begin
                    next_q.st = TS_FAIL;
                end else if (tick) begin
                    if (q.cnt <= CNT_W'(1)) begin
                        next_q.st = TS_OK;
                    end else begin
                        next_q.cnt = q.cnt - CNT_W'(1);
                    end
                end
            end
            default: begin
                next_q.st = TS_OK;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{st: TS_OK, cnt: '0};
        end else begin
            q <= next_q;
        end
    end

    assign unusable  = (q.st == TS_FAIL) || (q.st == TS_WTR);
    assign restoring = (q.st == TS_WTR);

endmodule

`default_nettype wire

// File: verilog/trs_top.sv
// What this block does
// - Priority 0 disables an input; 1..K enable it, 1 ranks best, ties allowed.
// - Each selector output carries its own enable set via priorities.
// - Clear drops forced and manual switches, keeps lockouts.
// - Lockout removes an enabled source; several lockouts may coexist.
// - Clear-lockout returns that source to the candidates.
// - Disabling a source by priority drops its lockout.
// - Forced switch to enabled unlocked source overrides all; newest wins.
// - Forced switch drops when its target is disabled or locked out.
// - Forced switch to a failing source clears sel_valid; locked mode then goes holdover.
// - Manual switch needs enabled, unlocked, healthy target; newest wins.
// - Manual switch drops on target disable, lockout or fail.
// - Otherwise pick best-priority healthy unlocked enabled input.
// - New signal fail is delayed by the hold-off time.
// - Cleared fail starts restore wait; source unusable until it ends.
// - Restore wait programmable 0 to 12 minutes in minute steps.
// - New restore wait applies only after the running one expires.
// - External fail is loss of signal; line fail adds loss of frame.
// - Free-run, locked, holdover by command; free-run until timing seen.
// - Locked goes holdover on fail or no timing, returns when clear.
// - Time-base state reported as normal or holdover.
// - Loss of every reference raises a notification.
// - Squelch suppresses reference output while chosen reference fails.
`timescale 1ns/100ps
`default_nettype none

module trs_top #(
    parameter int TICK_CYCLES = trs_pkg::TICK_CYCLES
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [trs_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [trs_pkg::NUM_LINE-1:0] line_los,
    input  wire logic [trs_pkg::NUM_LINE-1:0] line_lof,
    input  wire logic                        ext_los,
    input  wire logic                        ext_clk,
    output logic                             ext_ref_out,
    output logic      [trs_pkg::IDX_W-1:0]   sel_ref,
    output logic                             sel_valid,
    output logic                             holdover,
    output logic      [1:0]                  clock_mode,
    output logic                             loss_all_refs,
    output logic                             switch_report
);

    localparam int NI = trs_pkg::NUM_IN;
    localparam int NL = trs_pkg::NUM_LINE;
    localparam int PW = trs_pkg::PRIO_W;
    localparam int IW = trs_pkg::IDX_W;
    localparam int TW = trs_pkg::TMR_W;
    localparam int AW = trs_pkg::ACT_W;
    localparam int TICK_W = $clog2(TICK_CYCLES);

    typedef enum logic [1:0] {
        CS_FREE,
        CS_LOCKED,
        CS_HOLDOVER
    } trs_clk_st_t;

    typedef struct packed {
        logic [1:0]       mode_cmd;
        logic             squelch_en;
        logic             ext_mon;
        logic [NI*PW-1:0] prio;
        logic [3:0]       wtr_min;
        logic [3:0]       hold_off_time;
        logic [TW-1:0]    wtr_live;
        logic [NI-1:0]    lock;
        logic             fs_on;
        logic [IW-1:0]    fs_idx;
        logic             ms_on;
        logic [IW-1:0]    ms_idx;
        logic [NI-1:0]    los_s1;
        logic [NI-1:0]    los_s2;
        logic [NL-1:0]    lof_s1;
        logic [NL-1:0]    lof_s2;
        logic             clk_s1;
        logic             clk_s2;
        logic             clk_s3;
        logic [AW-1:0]    act_cnt;
        logic [TICK_W-1:0] tick_cnt;
        logic             tick;
        trs_clk_st_t      st;
        logic             ever;
        logic [IW-1:0]    sel_idx;
        logic             sel_ok;
        logic             holdover;
        logic [1:0]       mode_out;
        logic             loss_all;
        logic             switch_rpt;
        logic             ref_out;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } trs_top_state_t;

    trs_top_state_t q;
    trs_top_state_t next_q;

    logic [NI-1:0] raw_fail;
    logic [NI-1:0] unus;
    logic [NI-1:0] restoring;
    logic [NI-1:0] en;
    logic [NI-1:0] avail;
    logic          act_ok;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [PW-1:0] prio_of(
        input logic [NI*PW-1:0] v,
        input int               i
    );
        return v[i*PW +: PW];
    endfunction

    function automatic logic [NI-1:0] enabled(input logic [NI*PW-1:0] v);
        logic [NI-1:0] e;
        e = '0;
        for (int i = 0; i < NI; i++) begin
            e[i] = (prio_of(v, i) != '0) && (prio_of(v, i) <= PW'(NI));
        end
        return e;
    endfunction

    function automatic logic [TW-1:0] wtr_ticks(input logic [3:0] m);
        int mm;
        mm = (int'(m) > trs_pkg::WTR_MAX_MIN) ? trs_pkg::WTR_MAX_MIN
                                              : int'(m);
        return TW'(mm * trs_pkg::TICKS_PER_MIN);
    endfunction

    // Best priority, lowest index on a tie
    function automatic logic [IW:0] best_of(
        input logic [NI*PW-1:0] v,
        input logic [NI-1:0]    ok
    );
        logic          found;
        logic [IW-1:0] idx;
        logic [PW-1:0] bp;
        found = 1'b0;
        idx   = '0;
        bp    = '1;
        for (int i = 0; i < NI; i++) begin
            if (ok[i] && (!found || prio_of(v, i) < bp)) begin
                found = 1'b1;
                idx   = IW'(i);
                bp    = prio_of(v, i);
            end
        end
        return {found, idx};
    endfunction

    // ----------------------------------------------------------------
    // Fail timers, one per input
    // ----------------------------------------------------------------
    for (genvar gi = 0; gi < NI; gi++) begin : g_tmr
        trs_fail_timer #(
            .CNT_W (TW)
        ) u_tmr (
            .pclk       (pclk),
            .presetn    (presetn),
            .tick       (q.tick),
            .raw_fail   (raw_fail[gi]),
            .hold_ticks (q.hold_off_time),
            .wtr_ticks  (q.wtr_live),
            .unusable   (unus[gi]),
            .restoring  (restoring[gi])
        );
    end

    // ----------------------------------------------------------------
    // Signal fail derivation
    // ----------------------------------------------------------------
    // Dead link clock counts as loss of signal too
    assign act_ok = (q.act_cnt < AW'(trs_pkg::ACT_LIMIT));

    always_comb begin
        raw_fail = '0;
        // Line fail on loss of signal or frame
        for (int i = 0; i < NL; i++) begin
            raw_fail[i] = q.los_s2[i] | q.lof_s2[i];
        end
        // External fail on loss of signal
        raw_fail[NL] = (q.los_s2[NL] | ~act_ok) & q.ext_mon;
    end

    assign en    = enabled(q.prio);
    assign avail = en & ~q.lock & ~unus;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic          wr;
        logic [2:0]    op;
        logic [IW-1:0] p;
        logic [NI-1:0] en_n;
        logic [IW:0]   best;
        logic [31:0]   rd;
        logic          hit;
        logic          sq;

        next_q = q;
        en_n   = '0;
        best   = '0;
        rd     = '0;
        hit    = 1'b0;
        sq     = 1'b0;
        wr  = psel && penable && q.pready && pwrite;
        op  = pwdata[2:0];
        p   = pwdata[trs_pkg::CMD_IDX_LSB +: IW];

        // Synchronisers
        next_q.los_s1 = {ext_los, line_los};
        next_q.los_s2 = q.los_s1;
        next_q.lof_s1 = line_lof;
        next_q.lof_s2 = q.lof_s1;
        next_q.clk_s1 = ext_clk;
        next_q.clk_s2 = q.clk_s1;
        next_q.clk_s3 = q.clk_s2;

        // Link activity, saturating
        if (q.clk_s2 && !q.clk_s3) begin
            next_q.act_cnt = '0;
        end else if (act_ok) begin
            next_q.act_cnt = q.act_cnt + AW'(1);
        end

        next_q.tick = 1'b0;
        if (q.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
            next_q.tick_cnt = '0;
            next_q.tick     = 1'b1;
        end else begin
            next_q.tick_cnt = q.tick_cnt + TICK_W'(1);
        end

        // Configuration writes
        if (wr) begin
            case (paddr)
                trs_pkg::ADDR_CTRL: begin
                    next_q.mode_cmd   = pwdata[trs_pkg::CTRL_MODE_LSB +: 2];
                    next_q.squelch_en = pwdata[trs_pkg::CTRL_SQ_BIT];
                    next_q.ext_mon    = pwdata[trs_pkg::CTRL_MON_BIT];
                end
                trs_pkg::ADDR_PRIO: next_q.prio    = pwdata[NI*PW-1:0];
                trs_pkg::ADDR_WTR:  next_q.wtr_min = pwdata[3:0];
                trs_pkg::ADDR_HOT:  next_q.hold_off_time     = pwdata[3:0];
                default: ;
            endcase
        end

        // Restore time latched only when idle
        if (restoring == '0) begin
            next_q.wtr_live = wtr_ticks(q.wtr_min);
        end

        // Operator commands
        if (wr && paddr == trs_pkg::ADDR_CMD) begin
            case (op)
                trs_pkg::CMD_CLEAR: begin
                    next_q.fs_on = 1'b0;
                    next_q.ms_on = 1'b0;
                end
                trs_pkg::CMD_LOCKOUT: begin
                    if (en[p]) begin
                        next_q.lock[p] = 1'b1;
                    end
                end
                trs_pkg::CMD_CLR_LOCKOUT: next_q.lock[p] = 1'b0;
                trs_pkg::CMD_FORCED: begin
                    if (en[p] && !q.lock[p]) begin
                        next_q.fs_on  = 1'b1;
                        next_q.fs_idx = p;
                    end
                end
                trs_pkg::CMD_MANUAL: begin
                    if (avail[p]) begin
                        next_q.ms_on  = 1'b1;
                        next_q.ms_idx = p;
                    end
                end
                default: ;
            endcase
        end

        en_n        = enabled(next_q.prio);
        next_q.lock = next_q.lock & en_n;
        if (!en_n[next_q.fs_idx] || next_q.lock[next_q.fs_idx]) begin
            next_q.fs_on = 1'b0;
        end
        if (!en_n[next_q.ms_idx] || next_q.lock[next_q.ms_idx]
            || unus[next_q.ms_idx]) begin
            next_q.ms_on = 1'b0;
        end

        // Reference choice
        best = best_of(q.prio, avail);
        if (q.fs_on) begin
            // Failing forced target yields no reference
            next_q.sel_idx = q.fs_idx;
            next_q.sel_ok  = !unus[q.fs_idx];
        end else if (q.ms_on && avail[q.ms_idx]) begin
            next_q.sel_idx = q.ms_idx;
            next_q.sel_ok  = 1'b1;
        end else begin
            next_q.sel_idx = best[IW-1:0];
            next_q.sel_ok  = best[IW];
        end
        next_q.switch_rpt = (next_q.sel_idx != q.sel_idx)
                         || (next_q.sel_ok != q.sel_ok);

        case (q.mode_cmd)
            trs_pkg::MODE_LOCKED: begin
                if (q.sel_ok) begin
                    next_q.st   = CS_LOCKED;
                    next_q.ever = 1'b1;
                end else begin
                    next_q.st = q.ever ? CS_HOLDOVER : CS_FREE;
                end
            end
            // Holdover needs a history to hold
            trs_pkg::MODE_HOLD:
                next_q.st = q.ever ? CS_HOLDOVER : CS_FREE;
            default: next_q.st = CS_FREE;
        endcase
        case (next_q.st)
            CS_LOCKED:   next_q.mode_out = trs_pkg::MODE_LOCKED;
            CS_HOLDOVER: next_q.mode_out = trs_pkg::MODE_HOLD;
            default:     next_q.mode_out = trs_pkg::MODE_FREE;
        endcase
        next_q.holdover = (next_q.st == CS_HOLDOVER);
        next_q.loss_all = &raw_fail;

        sq = q.squelch_en && (!q.sel_ok || raw_fail[q.sel_idx]);
        next_q.ref_out = q.clk_s2 && !sq;

        // APB answer, one cycle after setup
        rd  = '0;
        hit = 1'b1;
        case (paddr)
            trs_pkg::ADDR_CTRL: begin
                rd[trs_pkg::CTRL_MODE_LSB +: 2] = q.mode_cmd;
                rd[trs_pkg::CTRL_SQ_BIT]        = q.squelch_en;
                rd[trs_pkg::CTRL_MON_BIT]       = q.ext_mon;
            end
            trs_pkg::ADDR_PRIO: rd[NI*PW-1:0] = q.prio;
            trs_pkg::ADDR_WTR:  rd[3:0]       = q.wtr_min;
            trs_pkg::ADDR_HOT:  rd[3:0]       = q.hold_off_time;
            trs_pkg::ADDR_CMD:  rd            = '0;
            trs_pkg::ADDR_STATUS: begin
                rd[trs_pkg::ST_SEL_LSB +: IW]  = q.sel_idx;
                rd[trs_pkg::ST_VALID_BIT]      = q.sel_ok;
                rd[trs_pkg::ST_HOLD_BIT]       = q.holdover;
                rd[trs_pkg::ST_LOSS_BIT]       = q.loss_all;
                rd[trs_pkg::ST_FS_BIT]         = q.fs_on;
                rd[trs_pkg::ST_MS_BIT]         = q.ms_on;
                rd[trs_pkg::ST_MODE_LSB +: 2]  = q.mode_out;
                rd[trs_pkg::ST_LOCK_LSB +: NI] = q.lock;
                rd[trs_pkg::ST_UNUS_LSB +: NI] = unus;
                rd[trs_pkg::ST_WTR_LSB +: NI]  = restoring;
            end
            default: hit = 1'b0;
        endcase
        next_q.pready  = psel && !penable;
        next_q.pslverr = psel && !penable && !hit;
        if (psel && !penable) begin
            next_q.prdata = rd;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q            <= '0;
            q.mode_cmd   <= trs_pkg::CTRL_MODE_RST;
            q.squelch_en <= trs_pkg::CTRL_SQ_RST;
            q.ext_mon    <= trs_pkg::CTRL_MON_RST;
            q.wtr_min    <= trs_pkg::WTR_RST;
            q.hold_off_time        <= trs_pkg::HOT_RST;
            q.st         <= CS_FREE;
            q.mode_out   <= trs_pkg::MODE_FREE;
            q.act_cnt    <= AW'(trs_pkg::ACT_LIMIT);
        end else begin
            q <= next_q;
        end
    end

    assign prdata        = q.prdata;
    assign pready        = q.pready;
    assign pslverr       = q.pslverr;
    assign ext_ref_out   = q.ref_out;
    assign sel_ref       = q.sel_idx;
    assign sel_valid     = q.sel_ok;
    assign holdover      = q.holdover;
    assign clock_mode    = q.mode_out;
    assign loss_all_refs = q.loss_all;
    assign switch_report = q.switch_rpt;

endmodule

`default_nettype wire

// File: testbench/trs_props.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// Port checks
// ----
module trs_props (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic [2:0] line_los,
    input wire logic [2:0] line_lof,
    input wire logic       ext_los,
    input wire logic [1:0] sel_ref,
    input wire logic       sel_valid,
    input wire logic [1:0] clock_mode,
    input wire logic       loss_all_refs,
    input wire logic       switch_report
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_dead; &(line_los | line_lof) && ext_los; endsequence
    sequence s_up0; !(line_los[0] | line_lof[0]); endsequence
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_ready_setup: assert property (s_setup |=> pready)
        else $error("no pready");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_loss_set: assert property (s_dead [*5] |-> loss_all_refs)
        else $error("loss not raised");
    a_loss_clr: assert property (s_up0 [*5] |-> !loss_all_refs)
        else $error("loss held");
    a_sw_report: assert property (switch_report ==
        ($changed(sel_ref) || $changed(sel_valid))) else $error("report");
    a_lock_ref: assert property (!sel_valid [*3] |->
        clock_mode != trs_pkg::MODE_LOCKED) else $error("locked no ref");
    a_lock_entry: assert property (clock_mode ==
        trs_pkg::MODE_LOCKED && $past(clock_mode) != trs_pkg::MODE_LOCKED
        |-> $past(sel_valid)) else $error("lock without ref");
endmodule
bind trs_top trs_props i_props (.*);
`default_nettype wire

// File: testbench/trs_ref_src.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// Line receivers and external clock
// ----
module trs_ref_src (
    input  wire logic       clk_on,
    input  wire logic [3:0] fail,
    output logic      [2:0] line_los,
    output logic      [2:0] line_lof,
    output logic            ext_los,
    output logic            ext_clk
);
    // Middle line fails by framing, the others by signal
    assign line_lof = fail[2:0] & 3'h2;
    assign line_los = fail[2:0] & 3'h5;
    assign ext_los  = fail[3];
    // Odd start keeps phase unrelated; a dead input gives no edges
    initial begin
        ext_clk = 1'b0;
        #137;
        forever #400 ext_clk = clk_on & ~fail[3] & ~ext_clk;
    end
endmodule
`default_nettype wire

// File: testbench/trs_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// Bench
// ----
module trs_top_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        clk_on, ext_los, ext_clk, ext_ref_out, sel_valid, er;
    logic        holdover, loss_all_refs;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  fail;
    logic [2:0]  line_los, line_lof;
    logic [1:0]  sel_ref, clock_mode;
    logic [15:0] rows [13] = '{16'h0005, 16'h1204, 16'h0206, 16'h1305,
        16'h2406, 16'h3506, 16'h0105, 16'h0026, 16'h3527, 16'h0105,
        16'h0405, 16'h2506, 16'h0045};
    int          error_cnt, checks_done, n;
    trs_top #(.TICK_CYCLES(10)) i_dut (.*, .switch_report());
    trs_ref_src i_src (.*);
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1)
            error_cnt++;
        if (ok !== 1'b1)
            $display("ERROR %0t %s", $time, m);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Request held until pready is seen at an edge
    task automatic apb(input logic w, logic [11:0] a, logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do @(posedge pclk);
        while (pready !== 1'b1 && ++n < 20);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
        if (n == 20) begin
            chk(1'b0, "apb timeout");
            wrap_up();
        end
        @(posedge pclk);
    endtask
    task automatic wait_sel(input logic [2:0] x);
        for (n = 0; n < 8000 && {sel_valid, sel_ref} !== x; n++)
            @(posedge pclk);
        repeat (8) @(posedge pclk);
        chk({sel_valid, sel_ref} === x, "selection");
        if (n == 8000) begin
            chk(1'b0, "selection timeout");
            wrap_up();
        end
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, fail, clk_on} = '0;
        repeat (20) @(posedge pclk);
        {presetn, clk_on} <= 2'h3;
        @(posedge pclk);
        apb(1'b0, trs_pkg::ADDR_CTRL, 32'h0);
        chk(rd === 32'h8 && clock_mode === 2'h0, "ctrl reset");
        apb(1'b0, 12'h020, 32'h0);
        chk(er === 1'b1, "unmapped");
        apb(1'b1, trs_pkg::ADDR_HOT, 32'h0);
        apb(1'b1, trs_pkg::ADDR_WTR, 32'h0);
        apb(1'b1, trs_pkg::ADDR_PRIO, 32'h8ca);
        apb(1'b1, trs_pkg::ADDR_CTRL, 32'hd);
        foreach (rows[i]) begin
            if (rows[i][15:8] != 8'h0)
                apb(1'b1, trs_pkg::ADDR_CMD, {24'h0, rows[i][15:8]});
            fail <= rows[i][7:4];
            wait_sel(rows[i][2:0]);
            $display("row %0d done", i);
        end
        apb(1'b1, trs_pkg::ADDR_CMD, 32'h14);
        fail <= 4'h2;
        wait_sel(3'h1);
        chk(holdover === 1'b1 && ext_ref_out === 1'b0, "holdover");
        fail <= 4'hf;
        repeat (8) @(posedge pclk);
        chk(loss_all_refs === 1'b1, "loss all");
        apb(1'b1, trs_pkg::ADDR_CMD, 32'h1);
        apb(1'b1, trs_pkg::ADDR_WTR, 32'h1);
        $display("holdover test done");
        fail <= 4'h2;
        wait_sel(3'h6);
        fail <= 4'h0;
        apb(1'b1, trs_pkg::ADDR_WTR, 32'h0);
        repeat (5000) @(posedge pclk);
        chk(sel_ref === 2'h2, "restore early");
        wait_sel(3'h5);
        $display("restore test done");
        apb(1'b1, trs_pkg::ADDR_HOT, 32'h3);
        fail <= 4'h2;
        repeat (10) @(posedge pclk);
        chk({sel_valid, sel_ref} === 3'h5, "hold-off early");
        wait_sel(3'h6);
        $display("hold-off test done");
        apb(1'b1, trs_pkg::ADDR_CTRL, 32'h2);
        repeat (4) @(posedge pclk);
        chk(clock_mode === 2'h2 && holdover === 1'b1, "hold cmd");
        $display("mode test done");
        wrap_up();
    end
endmodule
`default_nettype wire
